// >>> rtl/sacp_pkg.sv
// constants and types of the serial converter control port
// assumes a 100 MHz REF_CLK; the shift clock arrives as a plain pin
package sacp_pkg;
  // clock rate
  localparam int unsigned CLK_MHZ          = 100;
  // longest conversion time in high speed mode, in ns
  localparam int unsigned CONV_MAX_NS      = 2300;
  // longest power-up time after wake, in ns
  localparam int unsigned PWRUP_MAX_NS     = 1000;
  // longest times round down
  localparam int unsigned CONV_CYC_I       = (CONV_MAX_NS * CLK_MHZ) / 1000;
  localparam int unsigned PWRUP_CYC_I      = (PWRUP_MAX_NS * CLK_MHZ) / 1000;
  localparam logic [11:0] CONV_CYC         = 12'(CONV_CYC_I);
  localparam logic [11:0] PWRUP_CYC        = 12'(PWRUP_CYC_I);
  // result width and per-read bit count
  localparam int unsigned RES_W            = 10;
  localparam logic [3:0]  RES_BITS         = 4'hA;
  localparam logic [11:0] CNT_ZERO         = 12'h000;
  localparam logic [11:0] CNT_ONE          = 12'h001;
  localparam logic [3:0]  BIT_ZERO         = 4'h0;
  localparam logic [3:0]  BIT_ONE          = 4'h1;

  // power and conversion states, one-hot
  typedef enum logic [3:0] {
    SACP_DOWN  = 4'h1,
    SACP_WAKE  = 4'h2,
    SACP_IDLE  = 4'h4,
    SACP_CONV  = 4'h8
  } sacp_state_e;
endpackage : sacp_pkg

// >>> rtl/sacp_edge_sync.sv
// two-flop synchroniser with edge detect for one pin
// assumes the pin is asynchronous to clk
`timescale 1ns/10ps
module sacp_edge_sync #(
  // level the pin rests at; reset loads it so no false edge follows
  parameter logic IDLE_LEVEL = 1'b1
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // pin in
  input  wire logic pin,
  // synchronised level and edges
  output logic      level,
  output logic      rise,
  output logic      fall
);
  logic meta;
  logic sync;
  logic prev;
  logic next_meta;
  logic next_sync;
  logic next_prev;

  // shift; meta is read by sync only
  always_comb begin
    next_meta = pin;
    next_sync = meta;
    next_prev = sync;
  end

  // reset to the pin's idle level, so the first edges show no edge
  always_ff @(posedge clk) begin
    if (rst) begin
      meta <= IDLE_LEVEL;
      sync <= IDLE_LEVEL;
      prev <= IDLE_LEVEL;
    end else begin
      meta <= next_meta;
      sync <= next_sync;
      prev <= next_prev;
    end
  end

  assign level = sync;
  assign rise  = sync & ~prev;
  assign fall  = ~sync & prev;
endmodule : sacp_edge_sync

// >>> rtl/sacp_top.sv
// control and serial read-out of a 10-bit converter port
// assumes host drives CONVERT_START_N and SHIFT_CLK asynchronously
// How it works
// - falling convert-start while powered up puts track-and-hold in hold, starts conversion
// - rising convert-start enables the serial port; output drives low
// - convert-start level at conversion end selects power-down or stay up
// - high speed conversions complete within 2.3 us
// - wake from power-down completes within 1 us of rising edge
// - result shifts out one bit per shift-clock cycle
// - data bit updates on each shift-clock rising edge
// - after final falling shift edge, data output released
// - after reset the device sits powered down until a rising edge
// - conversion end returns track-and-hold to track
`timescale 1ns/10ps
module sacp_top (
  // clock and reset
  input  wire logic                        REF_CLK,
  input  wire logic                        RST,
  // host pins
  input  wire logic                        CONVERT_START_N,
  input  wire logic                        SHIFT_CLK,
  // serial data pin, three-state as out and enable
  output logic                             DATA_OUT,
  output logic                             DATA_OUT_EN,
  // analog core side
  input  wire logic [sacp_pkg::RES_W-1:0]  ADC_CODE,
  output logic                             HOLD,
  output logic                             POWERED,
  output logic                             CONV_DONE
);
  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic cs_level;
  logic cs_rise;
  logic cs_fall;
  logic sk_rise;
  logic sk_fall;

  // convert-start rests high between frames
  sacp_edge_sync #(
    .IDLE_LEVEL (1'b1)
  ) u_cs (
    .clk   (REF_CLK),
    .rst   (RST),
    .pin   (CONVERT_START_N),
    .level (cs_level),
    .rise  (cs_rise),
    .fall  (cs_fall)
  );

  // shift clock comes only from the host, so it is sampled, never made;
  // it rests low, so a reset to high would fake a fall after reset
  sacp_edge_sync #(
    .IDLE_LEVEL (1'b0)
  ) u_sk (
    .clk   (REF_CLK),
    .rst   (RST),
    .pin   (SHIFT_CLK),
    .level (),
    .rise  (sk_rise),
    .fall  (sk_fall)
  );

  // ****************************************************************
  // counter helpers
  // ****************************************************************
  // one step of the shared down counter; wake and conversion both use it
  function automatic logic [11:0] count_step(input logic [11:0] value);
    return value - sacp_pkg::CNT_ONE;
  endfunction : count_step

  // last cycle of a timed phase
  function automatic logic count_last(input logic [11:0] value);
    return value == sacp_pkg::CNT_ONE;
  endfunction : count_last

  // ****************************************************************
  // power and conversion control
  // ****************************************************************
  sacp_pkg::sacp_state_e state;
  sacp_pkg::sacp_state_e next_state;
  logic [11:0]           cnt;
  logic [11:0]           next_cnt;
  logic                  hold;
  logic                  next_hold;
  logic                  done;
  logic                  next_done;
  logic [sacp_pkg::RES_W-1:0] result;
  logic [sacp_pkg::RES_W-1:0] next_result;

  // a start during power-up is taken at once by letting wake fall into conv
  always_comb begin
    next_state  = state;
    next_cnt    = cnt;
    next_hold   = hold;
    next_done   = 1'b0;
    next_result = result;
    unique case (state)
      sacp_pkg::SACP_DOWN: begin
        // falls while asleep are dropped; the host must wake the part first
        if (cs_rise) begin
          next_state = sacp_pkg::SACP_WAKE;
          next_cnt   = sacp_pkg::PWRUP_CYC;
        end
      end
      sacp_pkg::SACP_WAKE: begin
        next_cnt = count_step(cnt);
        if (cs_fall) begin
          next_state = sacp_pkg::SACP_CONV;
          next_hold  = 1'b1;
          next_cnt   = sacp_pkg::CONV_CYC;
        end else if (count_last(cnt)) begin
          next_state = sacp_pkg::SACP_IDLE;
        end
      end
      sacp_pkg::SACP_IDLE: begin
        if (cs_fall) begin
          next_state = sacp_pkg::SACP_CONV;
          next_hold  = 1'b1;
          next_cnt   = sacp_pkg::CONV_CYC;
        end
      end
      sacp_pkg::SACP_CONV: begin
        next_cnt = count_step(cnt);
        // counter parks at zero after the last cycle, so it cannot wrap
        if (count_last(cnt)) begin
          next_hold   = 1'b0;
          next_done   = 1'b1;
          next_result = ADC_CODE;
          next_cnt    = sacp_pkg::CNT_ZERO;
          // low at the end keeps power, high powers down
          next_state  = cs_level ? sacp_pkg::SACP_DOWN
                                 : sacp_pkg::SACP_IDLE;
        end
      end
      default: begin
        next_state = sacp_pkg::SACP_DOWN;
      end
    endcase
  end

  // comes out of reset powered down
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      state  <= sacp_pkg::SACP_DOWN;
      cnt    <= sacp_pkg::CNT_ZERO;
      hold   <= 1'b0;
      done   <= 1'b0;
      result <= '0;
    end else begin
      state  <= next_state;
      cnt    <= next_cnt;
      hold   <= next_hold;
      done   <= next_done;
      result <= next_result;
    end
  end

  // ****************************************************************
  // serial read-out
  // ****************************************************************
  logic                       port_on;
  logic                       next_port_on;
  logic [sacp_pkg::RES_W-1:0] shreg;
  logic [sacp_pkg::RES_W-1:0] next_shreg;
  logic [3:0]                 bits;
  logic [3:0]                 next_bits;
  logic                       dout;
  logic                       next_dout;

  // the host keeps its first shift edge after the enabling rise, so
  // the rise simply reloads the shifter from the latest result;
  // a rise in mid-read also restarts the word from the msb
  always_comb begin
    next_port_on = port_on;
    next_shreg   = shreg;
    next_bits    = bits;
    next_dout    = dout;
    if (cs_rise) begin
      next_port_on = 1'b1;
      next_shreg   = result;
      next_bits    = sacp_pkg::BIT_ZERO;
      next_dout    = 1'b0;
    end else if (port_on) begin
      if (sk_rise && bits != sacp_pkg::RES_BITS) begin
        // msb first, one bit per shift cycle
        next_dout  = shreg[sacp_pkg::RES_W-1];
        next_shreg = {shreg[sacp_pkg::RES_W-2:0], 1'b0};
        next_bits  = bits + sacp_pkg::BIT_ONE;
      end else if (sk_fall && bits == sacp_pkg::RES_BITS) begin
        next_port_on = 1'b0;
      end
    end
  end

  // port starts off the bus so other parts can share it
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      port_on <= 1'b0;
      shreg   <= '0;
      bits    <= sacp_pkg::BIT_ZERO;
      dout    <= 1'b0;
    end else begin
      port_on <= next_port_on;
      shreg   <= next_shreg;
      bits    <= next_bits;
      dout    <= next_dout;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  // every pin below comes straight from a flop, except the power decode
  assign DATA_OUT    = dout;
  assign DATA_OUT_EN = port_on;
  assign HOLD        = hold;
  assign POWERED     = (state != sacp_pkg::SACP_DOWN);
  assign CONV_DONE   = done;
endmodule : sacp_top

// >>> dv/sacp_chk.sv
// checker on the converter port pins
// assumes it is bound onto sacp_top
// ****
// checks
// ****
`timescale 1ns/10ps
module sacp_chk (
  // clock and reset
  input  wire logic                       REF_CLK,
  input  wire logic                       RST,
  // host pins
  input  wire logic                       CONVERT_START_N,
  input  wire logic                       SHIFT_CLK,
  // serial data pin
  input  wire logic                       DATA_OUT,
  input  wire logic                       DATA_OUT_EN,
  // analog core side
  input  wire logic [sacp_pkg::RES_W-1:0] ADC_CODE,
  input  wire logic                       HOLD,
  input  wire logic                       POWERED,
  input  wire logic                       CONV_DONE
);
  // one domain, so one clocking and one disable
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RST);
  hold_start_a: assert property (
    $fell(CONVERT_START_N) && POWERED && !HOLD |-> ##[2:5] HOLD)
    else $error("hold missed");
  conv_len_a: assert property (
    $rose(HOLD) |-> ##229 HOLD ##1 !HOLD)
    else $error("conversion length wrong");
  done_pulse_a: assert property (
    $fell(HOLD) |-> CONV_DONE ##1 !CONV_DONE)
    else $error("done pulse wrong");
  pwr_down_a: assert property (
    CONV_DONE && CONVERT_START_N && $past(CONVERT_START_N, 3)
    |-> ##[1:2] !POWERED)
    else $error("no power-down");
  stay_up_a: assert property (
    CONV_DONE && !CONVERT_START_N && !$past(CONVERT_START_N, 3)
    |-> ##1 POWERED [*4])
    else $error("powered down in fast mode");
  wake_up_a: assert property (
    $rose(CONVERT_START_N) && !POWERED |-> ##[2:5] POWERED)
    else $error("no wake");
  port_on_a: assert property (
    $rose(CONVERT_START_N) |-> ##[2:5] DATA_OUT_EN)
    else $error("port not enabled");
  asleep_a: assert property (
    !POWERED |-> !HOLD)
    else $error("hold while down");
  // a reload on the enabling rise is excluded through the pin history
  bit_step_a: assert property (
    DATA_OUT_EN && $past(DATA_OUT_EN) && $past(CONVERT_START_N, 8) &&
    !$stable(DATA_OUT) |-> $past(SHIFT_CLK, 3))
    else $error("bit moved off a shift rise");
  release_a: assert property (
    $fell(DATA_OUT_EN) |-> !$past(SHIFT_CLK, 2))
    else $error("release not on a shift fall");
  cover property (CONV_DONE && POWERED);
  cover property ($fell(DATA_OUT_EN));
  cover property ($rose(POWERED));
endmodule : sacp_chk
bind sacp_top sacp_chk u_chk (.REF_CLK, .RST, .CONVERT_START_N, .SHIFT_CLK,
  .DATA_OUT, .DATA_OUT_EN, .HOLD, .POWERED, .CONV_DONE, .ADC_CODE);

// >>> dv/sacp_host.sv
// host model: shift clock and read-out of one word on request
// assumes go is raised only after the enabling convert-start rise
`timescale 1ns/10ps
module sacp_host (
  // reference clock, for the start request and the released-pin history
  input  wire logic       clk,
  // read request from the bench
  input  wire logic       go,
  // device data pin, as value and enable
  input  wire logic       data_out,
  input  wire logic       data_en,
  // shift clock to the device and read status
  output logic            sclk,
  output logic            busy,
  output logic [9:0]      word
);
  logic last = 1'b0;
  logic line;
  // a released pin shows no stale bit, so the slip cannot hide
  assign line = data_en ? data_out : ~last;
  always @(posedge clk) last <= line;
  // clock stands low outside frames and runs at 125 ns a period; its
  // edges start 1 ns after a clk rise, so none lands on an edge of clk
  initial begin
    sclk = 1'b0;
    busy = 1'b0;
    word = 10'h000;
    forever begin
      @(posedge clk iff go);
      busy = 1'b1;
      #1;
      repeat (10) begin
        sclk = 1'b1;
        #62.5;
        // the bit stands until the next rise, so take it at the fall
        word = {word[8:0], line};
        sclk = 1'b0;
        #62.5;
      end
      busy = 1'b0;
    end
  end
endmodule : sacp_host

// >>> dv/test_serial_adc_convert_port.sv
// bench: wake, convert in both power modes, read the word
// assumes sacp_top, sacp_host and the bound checker
`timescale 1ns/10ps
module test_serial_adc_convert_port;
  logic       REF_CLK, RST, CONVERT_START_N, SHIFT_CLK, go, busy;
  logic       DATA_OUT, DATA_OUT_EN, HOLD, POWERED, CONV_DONE;
  logic [9:0] ADC_CODE, word;
  int         fails = 0, tests_run = 0, cyc = 0, k;
  sacp_top u_dut (.REF_CLK, .RST, .CONVERT_START_N, .SHIFT_CLK, .DATA_OUT,
    .DATA_OUT_EN, .ADC_CODE, .HOLD, .POWERED, .CONV_DONE);
  sacp_host u_host (.clk(REF_CLK), .go, .data_out(DATA_OUT),
    .data_en(DATA_OUT_EN), .sclk(SHIFT_CLK), .busy, .word);
  // clock and a hang limit well past the roughly 1150 cycles needed
  initial begin
    REF_CLK = 1'b0;
    forever #5 REF_CLK = ~REF_CLK;
  end
  always @(posedge REF_CLK) begin
    cyc <= cyc + 1;
    if (cyc == 12000) begin
      fails = fails + 1;
      conclude();
    end
  end
  task check(input string nm, input logic [9:0] exp, input logic [9:0] got);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask : check
  task conclude;
    $display("checks %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : conclude
  task pin(input logic v, input int n);
    CONVERT_START_N = v;
    repeat (n) @(negedge REF_CLK);
  endtask : pin
  // pin level left at end picks the power mode
  task conv(input logic lvl);
    pin(1'b0, 5);
    check("hold", 10'h001, HOLD);
    CONVERT_START_N = lvl;
    for (k = 5; k < 300 && CONV_DONE !== 1'b1; k++) @(negedge REF_CLK);
    check("conv time", 10'h001, k >= 230 && k <= 238);
    check("track", 10'h000, HOLD);
    repeat (4) @(negedge REF_CLK);
    check("powered", {9'h000, ~lvl}, POWERED);
  endtask : conv
  task rd(input logic [9:0] code);
    check("port on", 10'h001, DATA_OUT_EN);
    go = 1'b1;
    @(negedge REF_CLK);
    go = 1'b0;
    for (k = 0; k < 300 && busy !== 1'b0; k++) @(negedge REF_CLK);
    check("word", code, word);
    repeat (2) @(negedge REF_CLK);
    check("port off", 10'h000, DATA_OUT_EN);
  endtask : rd
  task t_reset;
    check("asleep", 10'h000, POWERED);
    check("port idle", 10'h000, DATA_OUT_EN);
    pin(1'b0, 10);
    check("no start asleep", 10'h000, HOLD);
    pin(1'b1, 10);
    check("woken", 10'h001, POWERED);
  endtask : t_reset
  task t_auto(input logic [9:0] code);
    ADC_CODE = code;
    conv(1'b1);
    pin(1'b0, 5);
    pin(1'b1, 8);
    check("rewoken", 10'h001, POWERED);
    rd(code);
  endtask : t_auto
  task t_fast(input logic [9:0] code);
    ADC_CODE = code;
    conv(1'b0);
    pin(1'b1, 8);
    rd(code);
  endtask : t_fast
  // reset for three cycles with convert-start idle high
  initial begin
    RST = 1'b1;
    CONVERT_START_N = 1'b1;
    ADC_CODE = 10'h000;
    go = 1'b0;
    repeat (3) @(negedge REF_CLK);
    RST = 1'b0;
    @(negedge REF_CLK);
    t_reset();
    t_auto(10'h2C5);
    t_fast(10'h200);
    t_fast(10'h001);
    conclude();
  end
endmodule : test_serial_adc_convert_port
